/* File: design/gpio_pin_pkg.sv */
package gpio_pin_pkg;

    // ************************************************************
    // Port dimensions
    // ************************************************************
    localparam int NPINS_DEF = 30;
    localparam int SRC_W = 2;
    localparam int NSRC = 1 << SRC_W;
    localparam int SYNC_STAGES = 2;
    localparam int LEVEL_LATENCY = SYNC_STAGES + 1;

    // ************************************************************
    // Drive configurations, three bits per pin
    // ************************************************************
    localparam logic [2:0] DM_INPUT_ONLY = 3'h0;
    localparam logic [2:0] DM_WEAK_UP_STRONG_DN = 3'h1;
    localparam logic [2:0] DM_STRONG_UP_WEAK_DN = 3'h2;
    localparam logic [2:0] DM_OD_DRIVE_LOW = 3'h3;
    localparam logic [2:0] DM_OD_DRIVE_HIGH = 3'h4;
    localparam logic [2:0] DM_STRONG = 3'h5;
    localparam logic [2:0] DM_WEAK = 3'h6;

    // ************************************************************
    // Routing sources of the pin matrix
    // ************************************************************
    localparam logic [SRC_W-1:0] SRC_GPIO = 2'h0;
    localparam logic [SRC_W-1:0] SRC_PERIPH = 2'h1;
    localparam logic [SRC_W-1:0] SRC_I2C = 2'h2;
    localparam logic [SRC_W-1:0] SRC_DEBUG = 2'h3;

    // Per-pin configuration written by software
    typedef struct packed {
        logic [2:0] drive_mode;
        logic lvttl_sel;
        logic in_en;
        logic out_en;
        logic slew_slow;
        logic [SRC_W-1:0] src_sel;
    } pin_cfg_s;

    // Per-pin controls that reach the pad cell
    typedef struct packed {
        logic drv_en;
        logic drv_val;
        logic pull_up;
        logic pull_dn;
        logic in_en;
        logic lvttl_sel;
        logic slew_slow;
        logic [SRC_W-1:0] src_sel;
    } pad_ctl_s;

    localparam pad_ctl_s PAD_DISABLED = '0;
    localparam logic SYNC_RST_VAL = 1'h0;

endpackage

/* File: design/gpio_in_sync.sv */
module gpio_in_sync
    import gpio_pin_pkg::*;
#(
    parameter int W = NPINS_DEF
) (
    input wire logic clock_in,
    input wire logic sys_rst_in,
    input wire logic [W-1:0] din_in,
    output logic [W-1:0] dout_out
);

    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;

    // ************************************************************
    // Two-stage synchroniser
    // ************************************************************
    // Pads may toggle at any time; only the second stage is used
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            meta_r <= {W{SYNC_RST_VAL}};
            sync_r <= {W{SYNC_RST_VAL}};
        end else begin
            meta_r <= din_in;
            sync_r <= meta_r;
        end
    end

    assign dout_out = sync_r;

endmodule

/* File: design/gpio_pin_control.sv */
module gpio_pin_control
    import gpio_pin_pkg::*;
#(
    parameter int NPINS = NPINS_DEF
) (
    input wire logic clock_in,
    input wire logic sys_rst_in,
    input wire logic hold_in,
    input wire pin_cfg_s [NPINS-1:0] pin_cfg_in,
    input wire logic [NPINS-1:0][NSRC-1:0] src_dout_in,
    input wire logic [NPINS-1:0] pad_in_in,
    output logic [NPINS-1:0] pad_out_out,
    output logic [NPINS-1:0] pad_oe_out,
    output pad_ctl_s [NPINS-1:0] pad_ctl_out,
    output logic [NPINS-1:0] pin_level_out,
    output logic [NPINS-1:0][NSRC-1:0] src_din_out
);

    // ************************************************************
    // Drive decode
    // ************************************************************
    // Turns a configuration and an output bit into pad controls
    function automatic pad_ctl_s decode_pin(input pin_cfg_s cfg, input logic [NSRC-1:0] dout);
        pad_ctl_s ctl;
        logic [2:0] mode;
        logic d;
        ctl = PAD_DISABLED;
        d = dout[cfg.src_sel];
        // I2C needs a wired-AND bus, so the stored mode is overridden
        mode = (cfg.src_sel == SRC_I2C) ? DM_OD_DRIVE_LOW : cfg.drive_mode;
        ctl.drv_val = d;
        case (mode)
            DM_INPUT_ONLY: begin
                ctl.drv_en = 1'b0;
            end
            DM_WEAK_UP_STRONG_DN: begin
                ctl.drv_en = ~d;
                ctl.pull_up = d;
            end
            DM_STRONG_UP_WEAK_DN: begin
                ctl.drv_en = d;
                ctl.pull_dn = ~d;
            end
            DM_OD_DRIVE_LOW: begin
                ctl.drv_en = ~d;
            end
            DM_OD_DRIVE_HIGH: begin
                ctl.drv_en = d;
            end
            DM_STRONG: begin
                ctl.drv_en = 1'b1;
            end
            DM_WEAK: begin
                ctl.pull_up = d;
                ctl.pull_dn = ~d;
            end
            default: begin
                ctl.drv_en = 1'b0;
            end
        endcase
        // Output buffer off removes strong drive and pulls alike
        if (!cfg.out_en) begin
            ctl.drv_en = 1'b0;
            ctl.pull_up = 1'b0;
            ctl.pull_dn = 1'b0;
        end
        ctl.in_en = cfg.in_en;
        ctl.lvttl_sel = cfg.lvttl_sel;
        ctl.slew_slow = cfg.slew_slow;
        ctl.src_sel = cfg.src_sel;
        return ctl;
    endfunction

    pad_ctl_s [NPINS-1:0] ctl_r;
    pad_ctl_s [NPINS-1:0] ctl_nxt;
    logic [NPINS-1:0] level_r;
    logic [NPINS-1:0][NSRC-1:0] din_r;
    logic [NPINS-1:0] pad_sync;

    // ************************************************************
    // Pad control registers
    // ************************************************************
    // Next value for each pin of the port
    always_comb begin
        for (int i = 0; i < NPINS; i++) begin
            ctl_nxt[i] = decode_pin(pin_cfg_in[i], src_dout_in[i]);
        end
    end

    // Reset wins over hold so a reset always leaves pins safe
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            ctl_r <= {NPINS{PAD_DISABLED}};
        end else if (!hold_in) begin
            ctl_r <= ctl_nxt;
        end
    end

    // Pad drive straight from flip-flops, no glitches on the pins
    always_comb begin
        for (int i = 0; i < NPINS; i++) begin
            pad_out_out[i] = ctl_r[i].drv_val;
            pad_oe_out[i] = ctl_r[i].drv_en;
        end
    end
    assign pad_ctl_out = ctl_r;

    // ************************************************************
    // Input path
    // ************************************************************
    gpio_in_sync #(
        .W(NPINS)
    ) u_in_sync (
        .clock_in(clock_in),
        .sys_rst_in(sys_rst_in),
        .din_in(pad_in_in),
        .dout_out(pad_sync)
    );

    // Level reads zero while the input buffer is off
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            level_r <= '0;
        end else begin
            for (int i = 0; i < NPINS; i++) begin
                level_r[i] <= ctl_r[i].in_en & pad_sync[i];
            end
        end
    end

    // Input reaches only the source the matrix selected
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            din_r <= '0;
        end else begin
            for (int i = 0; i < NPINS; i++) begin
                for (int s = 0; s < NSRC; s++) begin
                    din_r[i][s] <= ctl_r[i].in_en & pad_sync[i]
                        & (ctl_r[i].src_sel == SRC_W'(s));
                end
            end
        end
    end

    assign pin_level_out = level_r;
    assign src_din_out = din_r;

    // ************************************************************
    // Checks
    // ************************************************************
    for (genvar g = 0; g < NPINS; g++) begin : g_chk
        logic upd;
        assign upd = !hold_in && !sys_rst_in;

        a_reset_disables: assert property (
            @(posedge clock_in) sys_rst_in |=> !pad_oe_out[g] && !pad_ctl_out[g].pull_up
                && !pad_ctl_out[g].pull_dn && !pad_ctl_out[g].in_en && !pin_level_out[g])
            else $error("pin not disabled after reset");

        a_hold_freezes: assert property (
            @(posedge clock_in) disable iff (sys_rst_in)
            hold_in |=> $stable(pad_ctl_out[g]))
            else $error("pin changed while held");

        a_input_only: assert property (
            @(posedge clock_in) disable iff (sys_rst_in)
            upd && pin_cfg_in[g].drive_mode == DM_INPUT_ONLY
                && pin_cfg_in[g].src_sel != SRC_I2C
            |=> !pad_oe_out[g] && !pad_ctl_out[g].pull_up && !pad_ctl_out[g].pull_dn)
            else $error("input-only pin drives");

        a_strong_both: assert property (
            @(posedge clock_in) disable iff (sys_rst_in)
            upd && pin_cfg_in[g].drive_mode == DM_STRONG && pin_cfg_in[g].out_en
                && pin_cfg_in[g].src_sel != SRC_I2C
            |=> pad_oe_out[g] && pad_out_out[g] == $past(src_dout_in[g][pin_cfg_in[g].src_sel]))
            else $error("strong mode wrong drive");

        a_weak_pulls: assert property (
            @(posedge clock_in) disable iff (sys_rst_in)
            upd && pin_cfg_in[g].drive_mode == DM_WEAK && pin_cfg_in[g].out_en
                && pin_cfg_in[g].src_sel != SRC_I2C
            |=> !pad_oe_out[g] && (pad_ctl_out[g].pull_up != pad_ctl_out[g].pull_dn)
                && pad_ctl_out[g].pull_up == pad_out_out[g])
            else $error("weak mode wrong pulls");

        a_i2c_open_drain: assert property (
            @(posedge clock_in) disable iff (sys_rst_in)
            upd && pin_cfg_in[g].src_sel == SRC_I2C && pin_cfg_in[g].out_en
            |=> !pad_ctl_out[g].pull_up && (pad_oe_out[g] == !pad_out_out[g])
                && pad_out_out[g] == $past(src_dout_in[g][SRC_I2C]))
            else $error("i2c pin not open drain");

        a_outbuf_off: assert property (
            @(posedge clock_in) disable iff (sys_rst_in)
            upd && !pin_cfg_in[g].out_en
            |=> !pad_oe_out[g] && !pad_ctl_out[g].pull_up && !pad_ctl_out[g].pull_dn)
            else $error("disabled output still drives");

        a_inbuf_off: assert property (
            @(posedge clock_in) disable iff (sys_rst_in)
            !pad_ctl_out[g].in_en |=> !pin_level_out[g] && src_din_out[g] == '0)
            else $error("disabled input still reads");

        a_level_latency: assert property (
            @(posedge clock_in) disable iff (sys_rst_in)
            // A reset in any of the last three cycles empties the synchroniser
            !$past(sys_rst_in) && !$past(sys_rst_in, 2) && !$past(sys_rst_in, 3)
                && $past(pad_ctl_out[g].in_en)
            |-> pin_level_out[g] == $past(pad_in_in[g], 3))
            else $error("pin level wrong or late");

        a_thresh_slew: assert property (
            @(posedge clock_in) disable iff (sys_rst_in)
            upd |=> pad_ctl_out[g].lvttl_sel == $past(pin_cfg_in[g].lvttl_sel)
                && pad_ctl_out[g].slew_slow == $past(pin_cfg_in[g].slew_slow))
            else $error("threshold or slew not applied");

        a_route_one: assert property (
            @(posedge clock_in) disable iff (sys_rst_in)
            $onehot0(src_din_out[g]) && (src_din_out[g] == '0 || pin_level_out[g])
                && src_din_out[g][$past(pad_ctl_out[g].src_sel)] == pin_level_out[g])
            else $error("input routed to wrong sources");
    end

endmodule

/* File: tb/gpio_pin_control_tb.sv */
module gpio_pin_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import gpio_pin_pkg::*;

    // ************************************************************
    // Signals and design under test
    // ************************************************************
    logic clock_in = 1'h0;
    logic sys_rst_in = 1'h1;
    logic hold_in = 1'h1;
    pin_cfg_s [3:0] pin_cfg = '0;
    logic [3:0][NSRC-1:0] src_dout = '0;
    logic [3:0] pad_in = 4'h0;
    logic [3:0] pad_out;
    logic [3:0] pad_oe;
    pad_ctl_s [3:0] pad_ctl;
    logic [3:0] pin_level;
    logic [3:0][NSRC-1:0] src_din;
    int miscompares = 0;
    int checks = 0;
    logic [3:0] e;

    gpio_pin_control #(.NPINS(4)) u_gpio_pin_control (
        .clock_in(clock_in),
        .sys_rst_in(sys_rst_in),
        .hold_in(hold_in),
        .pin_cfg_in(pin_cfg),
        .src_dout_in(src_dout),
        .pad_in_in(pad_in),
        .pad_out_out(pad_out),
        .pad_oe_out(pad_oe),
        .pad_ctl_out(pad_ctl),
        .pin_level_out(pin_level),
        .src_din_out(src_din)
    );

    // 125 MHz clock
    initial begin
        forever #4 clock_in = ~clock_in;
    end

    // ************************************************************
    // Helpers
    // ************************************************************
    task automatic chk(input logic got, input logic exp, input string msg);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask

    // Pin 0 only; pins 1..3 stay unconfigured
    task automatic apply(input pin_cfg_s c, input logic [NSRC-1:0] s);
        @(posedge clock_in);
        pin_cfg[0] <= c;
        src_dout[0] <= s;
        @(posedge clock_in);
        #1;
    endtask

    function automatic pin_cfg_s mk(input logic [2:0] m, input logic lv, input logic ie,
                                    input logic oe, input logic sl, input logic [1:0] s);
        mk = '{m, lv, ie, oe, sl, s};
    endfunction

    // Expected {drive, value, pull up, pull down} for a mode and data bit
    function automatic logic [3:0] dec(input logic [2:0] m, input logic d);
        case (m)
            DM_WEAK_UP_STRONG_DN: dec = d ? 4'h2 : 4'h8;
            DM_STRONG_UP_WEAK_DN: dec = d ? 4'hC : 4'h1;
            DM_OD_DRIVE_LOW: dec = d ? 4'h0 : 4'h8;
            DM_OD_DRIVE_HIGH: dec = d ? 4'hC : 4'h0;
            DM_STRONG: dec = {1'h1, d, 2'h0};
            DM_WEAK: dec = {2'h0, d, ~d};
            default: dec = 4'h0;
        endcase
    endfunction

    task automatic chk_drive(input logic [3:0] x);
        chk(pad_oe[0], x[3], "drive enable");
        if (x[3]) chk(pad_out[0], x[2], "drive value");
        chk(pad_ctl[0].pull_up, x[1], "pull up");
        chk(pad_ctl[0].pull_dn, x[0], "pull down");
        chk(pad_oe[1], 1'h0, "idle pin drives");
    endtask

    task automatic stop_test();
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Watchdog, far beyond the roughly ninety cycles the tests need
    initial begin
        #200000;
        miscompares++;
        stop_test();
    end

    // ************************************************************
    // Tests
    // ************************************************************
    initial begin
        // Reset must beat a strong drive config and hold
        pin_cfg[0] = mk(3'h5, 1'h1, 1'h1, 1'h1, 1'h1, SRC_GPIO);
        src_dout[0] = 4'hF;
        pad_in = 4'hF;
        repeat (4) @(posedge clock_in);
        // Release on the edge; outputs still show the last reset edge
        sys_rst_in <= 1'h0;
        hold_in <= 1'h0;
        #1;
        chk(|pad_oe, 1'h0, "drive in reset");
        chk(|pad_ctl, 1'h0, "pad controls in reset");
        chk(|pin_level, 1'h0, "input in reset");
        // Every drive mode against both data values
        for (int m = 0; m < 8; m++) begin
            for (int d = 0; d < 2; d++) begin
                apply(mk(3'(m), 1'h0, 1'h0, 1'h1, 1'h0, SRC_GPIO), 4'(d));
                chk_drive(dec(3'(m), 1'(d)));
            end
        end
        // Output buffer off kills drive and pulls in any mode
        apply(mk(DM_STRONG, 1'h0, 1'h0, 1'h0, 1'h0, SRC_GPIO), 4'h1);
        chk_drive(4'h0);
        apply(mk(DM_WEAK, 1'h0, 1'h0, 1'h0, 1'h0, SRC_GPIO), 4'h1);
        chk_drive(4'h0);
        // Routing: each source; I2C falls back to open drain low
        for (int s = 0; s < 4; s++) begin
            for (int v = 0; v < 2; v++) begin
                e = v ? ~(4'h1 << s) : (4'h1 << s);
                apply(mk(DM_STRONG, 1'h0, 1'h0, 1'h1, 1'h0, 2'(s)), e);
                chk_drive(s == 2 ? dec(DM_OD_DRIVE_LOW, e[s]) : dec(DM_STRONG, e[s]));
            end
        end
        // Threshold and slew fields reach the pad both ways
        apply(mk(DM_INPUT_ONLY, 1'h1, 1'h1, 1'h0, 1'h1, SRC_DEBUG), 4'h0);
        chk(pad_ctl[0].lvttl_sel, 1'h1, "lvttl");
        chk(pad_ctl[0].slew_slow, 1'h1, "slew slow");
        apply(mk(DM_INPUT_ONLY, 1'h0, 1'h1, 1'h0, 1'h0, SRC_DEBUG), 4'h0);
        chk(pad_ctl[0].lvttl_sel, 1'h0, "cmos");
        chk(pad_ctl[0].slew_slow, 1'h0, "slew fast");
        // Hold freezes drive and config until released
        apply(mk(DM_STRONG, 1'h1, 1'h1, 1'h1, 1'h1, SRC_GPIO), 4'h1);
        @(posedge clock_in);
        hold_in <= 1'h1;
        apply(mk(DM_INPUT_ONLY, 1'h0, 1'h0, 1'h0, 1'h0, SRC_DEBUG), 4'h0);
        repeat (3) @(posedge clock_in);
        #1;
        chk_drive(4'hC);
        chk(pad_ctl[0].lvttl_sel, 1'h1, "held threshold");
        chk(pad_ctl[0].src_sel[0], 1'h0, "held source");
        @(posedge clock_in);
        hold_in <= 1'h0;
        repeat (2) @(posedge clock_in);
        #1;
        chk_drive(4'h0);
        // Input level read while driving the opposite value
        apply(mk(DM_STRONG, 1'h0, 1'h1, 1'h1, 1'h0, SRC_PERIPH), 4'h0);
        @(posedge clock_in);
        pad_in <= 4'h0;
        repeat (4) @(posedge clock_in);
        // Pin 1 sees a high pad too, but its input buffer is off
        pad_in <= 4'hF;
        repeat (2) @(posedge clock_in);
        #1;
        chk(pin_level[0], 1'h0, "pin level too early");
        @(posedge clock_in);
        #1;
        chk(pin_level[0], 1'h1, "pin level");
        chk(src_din[0][1], 1'h1, "selected source input");
        chk(src_din[0][0], 1'h0, "unselected source input");
        chk(pin_level[1], 1'h0, "input off pin");
        // Input buffer off forces the level low
        apply(mk(DM_STRONG, 1'h0, 1'h0, 1'h1, 1'h0, SRC_PERIPH), 4'h0);
        repeat (2) @(posedge clock_in);
        #1;
        chk(pin_level[0], 1'h0, "input disabled");
        chk(src_din[0][1], 1'h0, "source input disabled");
        // Reset in mid-run beats hold and a live strong drive
        apply(mk(DM_STRONG, 1'h1, 1'h1, 1'h1, 1'h1, SRC_GPIO), 4'h1);
        @(posedge clock_in);
        hold_in <= 1'h1;
        sys_rst_in <= 1'h1;
        @(posedge clock_in);
        #1;
        chk(|pad_oe, 1'h0, "drive after mid reset");
        chk(|pad_ctl, 1'h0, "pad controls after mid reset");
        chk(|pin_level, 1'h0, "input after mid reset");
        @(posedge clock_in);
        sys_rst_in <= 1'h0;
        hold_in <= 1'h0;
        @(posedge clock_in);
        #1;
        chk_drive(4'hC);
        stop_test();
    end
endmodule
